// file: logic/usb_select_consts.vh
// Notes on behaviour
// - Every reset clears the whole select register to zero.
// - All select bits read and write, except bit 6 which is read only.
// - Writes to the select register are ignored while the controller is busy.
// - Low five bits are the target index: 0 idle, 1..5 the USB registers.
`ifndef USB_SELECT_CONSTS_VH
`define USB_SELECT_CONSTS_VH
`define SEL_REG_OFFSET      8'h04
`define SEL_RESET           8'h00
`define SEL_RO_BIT          6
`define SEL_WRITE_MASK      8'hBF
`define SEL_INDEX_WIDTH     5
`define IDX_IDLE            5'h00
`define IDX_FUNC_ADDR       5'h01
`define IDX_CONTROL         5'h02
`define IDX_CONFIG          5'h03
`define IDX_INT_ENABLE      5'h04
`define IDX_INT_STATUS      5'h05
`define STATUS_REG_OFFSET   8'h08
`define AXI_OKAY            2'h0
`define AXI_SLVERR          2'h2
`endif

// file: logic/usb_select_decoder.v
`include "usb_select_consts.vh"
// Turns the select index into one-hot target strobes
module usb_select_decoder
(
   input  wire [4:0] index,
   output reg  [4:0] target_onehot,
   output reg        target_valid
);
   // Idle and unused indexes select nothing
   always @*
   begin
      target_onehot = 5'h00;
      target_valid  = 1'b1;
      case (index)
         `IDX_FUNC_ADDR:  target_onehot = 5'h01;
         `IDX_CONTROL:    target_onehot = 5'h02;
         `IDX_CONFIG:     target_onehot = 5'h04;
         `IDX_INT_ENABLE: target_onehot = 5'h08;
         `IDX_INT_STATUS: target_onehot = 5'h10;
         default:         target_valid  = 1'b0;
      endcase
   end
endmodule

// file: logic/usb_indirect_register_selector.v
// Decided for this implementation: the AXI4-Lite register port.
`include "usb_select_consts.vh"
module usb_indirect_register_selector
(
   input  wire        sys_clk,
   input  wire        reset,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        usb_controller_busy,
   input  wire        select_bit6_in,
   output reg  [4:0]  usb_select_index,
   output reg  [4:0]  usb_target_onehot,
   output reg         usb_target_valid
);
   reg  [7:0]  usb_register_select_reg;
   reg  [7:0]  usb_register_select_next;
   reg  [7:0]  awaddr_reg;
   reg  [31:0] wdata_reg;
   reg  [3:0]  wstrb_reg;
   reg         aw_full_reg;
   reg         w_full_reg;
   reg  [2:0]  busy_sync_reg;
   reg  [2:0]  bit6_sync_reg;
   reg         busy_reg;
   reg         bit6_reg;
   reg  [31:0] read_word;
   reg  [1:0]  read_resp;
   wire [4:0]  dec_onehot;
   wire        dec_valid;
   wire        do_write;
   wire        sel_hit;
   wire        status_hit;
   wire        select_write;

   // Registers sit on word boundaries; the two low address bits are dropped
   function [7:0] word_address;
      input [7:0] byte_address;
      begin
         word_address = {byte_address[7:2], 2'b00};
      end
   endfunction

   // Write channels accepted independently, one write at a time
   assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
   assign do_write      = aw_full_reg && w_full_reg;
   assign sel_hit       = (awaddr_reg == `SEL_REG_OFFSET);
   assign status_hit    = (awaddr_reg == `STATUS_REG_OFFSET);

   // A select write lands only with its low byte lane on and the controller idle
   assign select_write  = do_write && sel_hit && wstrb_reg[0] && !busy_reg;

   // Read side takes a new address only once the last answer is gone
   assign s_axi_arready = !s_axi_rvalid;

   // Decoder shared by the controller outputs
   usb_select_decoder u_dec
   (
      .index         (usb_register_select_reg[4:0]),
      .target_onehot (dec_onehot),
      .target_valid  (dec_valid)
   );

   // Busy pin through three flops; change accepted when last two agree
   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         busy_sync_reg <= 3'h0;
         busy_reg      <= 1'b0;
      end
      else
      begin
         busy_sync_reg <= {busy_sync_reg[1:0], usb_controller_busy};
         if (busy_sync_reg[1] == busy_sync_reg[2])
            busy_reg <= busy_sync_reg[2];
      end
   end

   // Bit 6 pin filtered the same way; a one-cycle glitch never reaches the register
   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         bit6_sync_reg <= 3'h0;
         bit6_reg      <= 1'b0;
      end
      else
      begin
         bit6_sync_reg <= {bit6_sync_reg[1:0], select_bit6_in};
         if (bit6_sync_reg[1] == bit6_sync_reg[2])
            bit6_reg <= bit6_sync_reg[2];
      end
   end

   // Write channels: address and data held until both are in
   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         awaddr_reg   <= 8'h00;
         wdata_reg    <= 32'h0000_0000;
         wstrb_reg    <= 4'h0;
         aw_full_reg  <= 1'b0;
         w_full_reg   <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awaddr_reg  <= word_address(s_axi_awaddr);
            aw_full_reg <= 1'b1;
         end
         else if (do_write)
            aw_full_reg <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
            w_full_reg <= 1'b1;
         end
         else if (do_write)
            w_full_reg <= 1'b0;
      end
   end

   // Write response: busy or masked select writes still answer OKAY
   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `AXI_OKAY;
      end
      else if (do_write)
      begin
         s_axi_bvalid <= 1'b1;
         if (sel_hit || status_hit)
            s_axi_bresp <= `AXI_OKAY;
         else
            s_axi_bresp <= `AXI_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // Next select value: software bits from the write, bit 6 from the pin
   always @*
   begin
      usb_register_select_next = usb_register_select_reg;
      usb_register_select_next[`SEL_RO_BIT] = bit6_reg;
      if (select_write)
      begin
         usb_register_select_next[5:0] = wdata_reg[5:0];
         usb_register_select_next[7]   = wdata_reg[7];
      end
   end

   // Select register; every reset clears all eight bits
   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         usb_register_select_reg <= `SEL_RESET;
      else
         usb_register_select_reg <= usb_register_select_next;
   end

   // Read word chosen by address; unmapped words read zero with SLVERR
   always @*
   begin
      read_word = 32'h0000_0000;
      read_resp = `AXI_OKAY;
      case (word_address(s_axi_araddr))
         `SEL_REG_OFFSET:    read_word = {24'h000000, usb_register_select_reg};
         `STATUS_REG_OFFSET: read_word = {25'h0, usb_target_valid, busy_reg, usb_select_index};
         default:            read_resp = `AXI_SLVERR;
      endcase
   end

   // Read answer held until the master takes it
   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `AXI_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= read_word;
         s_axi_rresp  <= read_resp;
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // Decoded target handed to the controller; idle index strobes nothing
   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         usb_select_index  <= `IDX_IDLE;
         usb_target_onehot <= 5'h00;
         usb_target_valid  <= 1'b0;
      end
      else
      begin
         usb_select_index  <= usb_register_select_reg[4:0];
         usb_target_onehot <= dec_onehot;
         usb_target_valid  <= dec_valid;
      end
   end
endmodule

// file: tb/usb_selector_assertions.sv
module usb_selector_checker
(
   input wire       sys_clk,
   input wire       reset,
   input wire       s_axi_bvalid,
   input wire       s_axi_bready,
   input wire [4:0] usb_select_index,
   input wire [4:0] usb_target_onehot,
   input wire       usb_target_valid
);
   timeunit 1ns;
   timeprecision 1ns;
   // Index values that name a USB register, and the strobe each one should raise
   wire       index_mapped    = (usb_select_index >= 5'h01) && (usb_select_index <= 5'h05);
   wire [4:0] expected_strobe = 5'h01 << (usb_select_index - 5'h01);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   // Response raised and not yet taken by the master
   sequence resp_pending;
      s_axi_bvalid && !s_axi_bready;
   endsequence
   // Select index held at zero while reset is high
   chk_reset_clear: assert property (disable iff (1'b0) reset |-> usb_select_index == 5'h00)
      else $error("select index not cleared in reset");
   // A valid target strobes exactly one register
   chk_onehot_target: assert property (usb_target_valid |-> $onehot(usb_target_onehot))
      else $error("target strobe not one-hot");
   chk_idle_none: assert property (!usb_target_valid |-> usb_target_onehot == 5'h00)
      else $error("strobe raised without valid target");
   // Only indexes 1 to 5 count as a target, each with its own strobe
   chk_valid_range: assert property (usb_target_valid == index_mapped)
      else $error("target valid disagrees with index");
   chk_index_map: assert property (usb_target_valid |-> usb_target_onehot == expected_strobe)
      else $error("strobe does not match index");
   // Index only moves after a completed write
   chk_index_written: assert property ($changed(usb_select_index) |-> $past(s_axi_bvalid, 1))
      else $error("index changed without a write");
   chk_bvalid_hold: assert property (resp_pending |=> s_axi_bvalid)
      else $error("write response dropped early");
endmodule

bind usb_indirect_register_selector usb_selector_checker chk (.sys_clk(sys_clk), .reset(reset),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .usb_select_index(usb_select_index),
   .usb_target_onehot(usb_target_onehot), .usb_target_valid(usb_target_valid));

// file: tb/usb_indirect_register_selector_tb.sv
`define CK(n, e, s) begin checks++; if ((s) !== (e)) begin err_count++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module usb_indirect_register_selector_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 0, reset = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, busy = 0, b6 = 0;
   logic [7:0] aa = 8'h00, ra = 8'h00;
   logic [31:0] wd = 32'h0, rd;
   logic [1:0] rs, bresp;
   logic awr, wr_, bv, arr, rv;
   logic [4:0] idx, oh;
   logic tv;
   int err_count = 0, checks = 0, cyc = 0;
   usb_indirect_register_selector uut (.sys_clk(sys_clk), .reset(reset), .s_axi_awaddr(aa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_),
      .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ra), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rs), .s_axi_rvalid(rv), .s_axi_rready(rr),
      .usb_controller_busy(busy), .select_bit6_in(b6), .usb_select_index(idx), .usb_target_onehot(oh),
      .usb_target_valid(tv));
   always #50 sys_clk = ~sys_clk;
   // Cuts a hung run short
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 4000)
      begin
         err_count++;
         close_out();
      end
   end
   task close_out();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // AXI write, each channel released at its own handshake
   task axw(input [7:0] a, input [31:0] d);
      logic ta, tw;
      @(posedge sys_clk);
      aa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
      while (awv || wv)
      begin
         @(negedge sys_clk); ta = awv && awr; tw = wv && wr_;
         @(posedge sys_clk); if (ta) awv <= 0; if (tw) wv <= 0;
      end
      do @(negedge sys_clk); while (!bv);
      `CK("write response", 2'h0, bresp)
      @(posedge sys_clk); br <= 0;
      repeat (3) @(posedge sys_clk);
   endtask
   task axr(input [7:0] a, output [31:0] d, output [1:0] r);
      @(posedge sys_clk);
      ra <= a; arv <= 1; rr <= 1;
      do @(negedge sys_clk); while (!arr);
      @(posedge sys_clk); arv <= 0;
      do @(negedge sys_clk); while (!rv);
      d = rd; r = rs;
      @(posedge sys_clk); rr <= 0;
   endtask
   task t_reset();
      logic [31:0] d; logic [1:0] r;
      axr(8'h04, d, r);
      `CK("select after reset", 32'h00000000, d)
      `CK("index after reset", 5'h00, idx)
      `CK("strobe after reset", 5'h00, oh)
      $display("test reset done");
   endtask
   task t_decode();
      logic [31:0] d; logic [1:0] r;
      for (int i = 1; i <= 5; i++)
      begin
         axw(8'h04, i);
         axr(8'h04, d, r);
         `CK("select readback", i, d)
         `CK("select index", i, idx)
         `CK("target strobe", 5'h01 << (i - 1), oh)
         `CK("target valid", 1'b1, tv)
         axr(8'h08, d, r);
         `CK("status word", 32'h40 + i, d)
      end
      $display("test decode done");
   endtask
   task t_mask_busy();
      logic [31:0] d; logic [1:0] r;
      axw(8'h04, 32'h000000FF);
      axr(8'h04, d, r);
      `CK("bit six read only", 32'h000000BF, d)
      `CK("unused index idle", 5'h00, oh)
      busy <= 1; repeat (6) @(posedge sys_clk);
      axw(8'h04, 32'h00000002);
      axr(8'h04, d, r);
      `CK("write while busy", 32'h000000BF, d)
      busy <= 0;
      axr(8'h10, d, r);
      `CK("unmapped response", 2'h2, r)
      b6 <= 1; repeat (6) @(posedge sys_clk);
      axw(8'h04, 32'h00000000);
      axr(8'h04, d, r);
      `CK("bit six from pin", 32'h00000040, d)
      b6 <= 0;
      $display("test mask busy done");
   endtask
   initial
   begin
      reset <= 1;
      repeat (16) @(posedge sys_clk);
      reset <= 0;
      t_reset();
      t_decode();
      t_mask_busy();
      reset <= 1; @(posedge sys_clk); reset <= 0;
      t_reset();
      close_out();
   end
endmodule
